// [design/spt_top.sv]
// Function
// - Timer function counts one per machine cycle of twelve clocks.
// - Counter function counts pin falling edges sampled once per machine cycle.
// - Count only when run bit set and gate clear or interrupt pin high.
// - Mode 0 is 13 bits with 5-bit prescaler, mode 1 is 16 bits.
// - Mode 2 low byte counts and reloads from high byte on overflow.
// - Mode 3 splits timer A; high byte uses timer B run and flag.
// - Overflow flags set on overflow, cleared by software or vectoring.
// - Interrupt type bit selects falling edge or low level triggering.
// - Buffer write starts transmit; buffer read returns separate receive register.
// - Receiver is double buffered, a new frame shifts while old is held.
// - Two mode bits choose shift register or one of three UART modes.
// - Receive and transmit complete flags set by hardware, cleared by software.
// - Mode 0 receive starts on enable and clear flag, else start bit.
// - Mode 0 shifts eight bits LSB first on data pin with clock out.
// - Mode 0 transfer starts after one machine cycle, ends in tenth.
// - Mode 1 frame is start, eight data bits, stop into ninth field.
// - Receiver detects falling edge, votes samples seven, eight and nine.
// - Frame is kept only if flag clear and filter passes, else dropped.
// - Modes 2 and 3 send eleven bits with programmable ninth bit.
// - Modes 2 and 3 transmit ends at eleventh bit tick after write.
// - Mode 2 runs at clock over 64, or over 32 when doubled.
// - Modes 1 and 3 run at timer B overflow rate over 32, doubled.
// - Serial interrupt request is the OR of both complete flags.
//
// Our own choices: the register addresses and the Wishbone register port.
`timescale 1ns/1ps
`default_nettype none
`include "spt_map.svh"
module spt_top
	import spt_pkg::*;
(
	// Clock, reset, enable
	input  wire logic        sys_clk_i,
	input  wire logic        rst_i,
	input  wire logic        ce_i,
	// Wishbone slave
	input  wire logic        wb_cyc_i,
	input  wire logic        wb_stb_i,
	input  wire logic        wb_we_i,
	input  wire logic [3:0]  wb_sel_i,
	input  wire logic [7:0]  wb_adr_i,
	input  wire logic [31:0] wb_dat_i,
	output logic [31:0]      wb_dat_o,
	output logic             wb_ack_o,
	// Timer and interrupt pins
	input  wire logic        timer_a_pin_i,
	input  wire logic        timer_b_pin_i,
	input  wire logic        ext_irq_a_pin_i,
	input  wire logic        ext_irq_b_pin_i,
	// Serial pins
	input  wire logic        rxd_i,
	output logic             rxd_o,
	output logic             rxd_oe_o,
	output logic             txd_o,
	// Interrupt requests and vectoring
	input  wire logic [3:0]  vec_ack_i,
	output logic [4:0]       irq_req_o
);
	// ------------------------------------------------------------
	// Register bus
	// ------------------------------------------------------------
	logic [7:0]  timer_mode_config_reg;
	logic [7:0]  timer_run_and_flags_reg;
	logic [7:0]  serial_port_control_reg;
	logic [7:0]  power_control_reg;
	logic [7:0]  serial_buffer_reg;
	logic [7:0]  a_lo, a_hi, b_lo, b_hi;
	logic [31:0] rdata;
	spt_acc_s    acc;

	// Reads load data as ack rises; writes land one edge later, as ack falls
	assign acc.wr  = wb_cyc_i & wb_stb_i & wb_we_i & wb_sel_i[0] & wb_ack_o;
	assign acc.rd  = wb_cyc_i & wb_stb_i & ~wb_we_i & ~wb_ack_o;
	assign acc.adr = wb_adr_i;
	assign acc.dat = wb_dat_i[7:0];

	// Read mux, unmapped offsets read zero
	always_comb begin
		rdata = `SPT_RST_WORD;
		case (acc.adr)
			`SPT_OFS_TIMER_MODE:  rdata[7:0] = timer_mode_config_reg;
			`SPT_OFS_TIMER_RUN:   rdata[7:0] = timer_run_and_flags_reg;
			`SPT_OFS_SERIAL_CTRL: rdata[7:0] = serial_port_control_reg;
			`SPT_OFS_SERIAL_BUF:  rdata[7:0] = serial_buffer_reg;
			`SPT_OFS_POWER_CTRL:  rdata[7:0] = power_control_reg;
			`SPT_OFS_A_LOW:       rdata[7:0] = a_lo;
			`SPT_OFS_A_HIGH:      rdata[7:0] = a_hi;
			`SPT_OFS_B_LOW:       rdata[7:0] = b_lo;
			`SPT_OFS_B_HIGH:      rdata[7:0] = b_hi;
			default:              rdata = `SPT_RST_WORD;
		endcase
	end

	// One wait-free ack per request; every address answers
	always_ff @(posedge sys_clk_i) begin
		if (rst_i) begin
			wb_ack_o <= 1'b0;
			wb_dat_o <= `SPT_RST_WORD;
		end else if (ce_i) begin
			wb_ack_o <= wb_cyc_i & wb_stb_i & ~wb_ack_o;
			if (acc.rd) begin
				wb_dat_o <= rdata;
			end
		end
	end

	logic wr_timer_mode_config, wr_timer_run_and_flags, wr_serial_port_control, wr_serial_buffer, wr_power_control_reg;
	assign wr_timer_mode_config = acc.wr & (acc.adr == `SPT_OFS_TIMER_MODE);
	assign wr_timer_run_and_flags = acc.wr & (acc.adr == `SPT_OFS_TIMER_RUN);
	assign wr_serial_port_control = acc.wr & (acc.adr == `SPT_OFS_SERIAL_CTRL);
	assign wr_serial_buffer = acc.wr & (acc.adr == `SPT_OFS_SERIAL_BUF);
	assign wr_power_control_reg = acc.wr & (acc.adr == `SPT_OFS_POWER_CTRL);

	// Configuration registers cleared at reset
	always_ff @(posedge sys_clk_i) begin
		if (rst_i) begin
			timer_mode_config_reg <= `SPT_RST_BYTE;
			power_control_reg     <= `SPT_RST_BYTE;
		end else if (ce_i) begin
			if (wr_timer_mode_config) timer_mode_config_reg <= acc.dat;
			if (wr_power_control_reg) power_control_reg <= acc.dat;
		end
	end

	// ------------------------------------------------------------
	// Machine cycle and pin sampling
	// ------------------------------------------------------------
	logic [3:0] phase_reg;
	logic       mc_tick;
	assign mc_tick = ce_i & (phase_reg == `SPT_MC_LAST);

	// Twelve clocks per machine cycle
	always_ff @(posedge sys_clk_i) begin
		if (rst_i) begin
			phase_reg <= 4'h0;
		end else if (ce_i) begin
			phase_reg <= mc_tick ? 4'h0 : phase_reg + 4'h1;
		end
	end

	logic [3:0] pins, falls, lows;
	assign pins = {ext_irq_b_pin_i, ext_irq_a_pin_i,
		timer_b_pin_i, timer_a_pin_i};

	// Counter inputs and interrupt inputs share one sampler design
	genvar gi;
	generate
		for (gi = 0; gi < 4; gi++) begin : g_samp
			spt_edge_sampler u_samp (
				.sys_clk_i (sys_clk_i),
				.rst_i     (rst_i),
				.ce_i      (ce_i),
				.tick_i    (mc_tick),
				.pin_i     (pins[gi]),
				.fall_o    (falls[gi]),
				.low_o     (lows[gi])
			);
		end
	endgenerate

	// ------------------------------------------------------------
	// Timers
	// ------------------------------------------------------------
	spt_tcfg_s cfg_a, cfg_b;
	logic      ovf_a, ovf_b, split_ovf, a_split;
	assign cfg_a   = spt_tcfg_s'(timer_mode_config_reg[`SPT_TIMER_MODE_CONFIG_A]);
	assign cfg_b   = spt_tcfg_s'(timer_mode_config_reg[`SPT_TIMER_MODE_CONFIG_B]);
	assign a_split = (cfg_a.mode == SPT_TM_SPLIT);

	spt_timer #(.SPLIT(1'b1)) u_timer_a (
		.sys_clk_i   (sys_clk_i),
		.rst_i       (rst_i),
		.ce_i        (ce_i),
		.mc_tick_i   (mc_tick),
		.cfg_i       (cfg_a),
		.run_i       (timer_run_and_flags_reg[`SPT_TC_RUN_A]),
		.gate_pin_i  (ext_irq_a_pin_i),
		.cnt_pulse_i (falls[0]),
		.split_run_i (timer_run_and_flags_reg[`SPT_TC_RUN_B]),
		.wr_lo_i     (acc.wr & (acc.adr == `SPT_OFS_A_LOW)),
		.wr_hi_i     (acc.wr & (acc.adr == `SPT_OFS_A_HIGH)),
		.wdata_i     (acc.dat),
		.lo_o        (a_lo),
		.hi_o        (a_hi),
		.ovf_o       (ovf_a),
		.split_ovf_o (split_ovf)
	);

	spt_timer #(.SPLIT(1'b0)) u_timer_b (
		.sys_clk_i   (sys_clk_i),
		.rst_i       (rst_i),
		.ce_i        (ce_i),
		.mc_tick_i   (mc_tick),
		.cfg_i       (cfg_b),
		.run_i       (timer_run_and_flags_reg[`SPT_TC_RUN_B]),
		.gate_pin_i  (ext_irq_b_pin_i),
		.cnt_pulse_i (falls[1]),
		.split_run_i (1'b0),
		.wr_lo_i     (acc.wr & (acc.adr == `SPT_OFS_B_LOW)),
		.wr_hi_i     (acc.wr & (acc.adr == `SPT_OFS_B_HIGH)),
		.wdata_i     (acc.dat),
		.lo_o        (b_lo),
		.hi_o        (b_hi),
		.ovf_o       (ovf_b),
		.split_ovf_o ()
	);

	// Event sets beat software or vector clears in the same cycle
	logic [7:0] tc_set, tc_clr;
	always_comb begin
		tc_set = `SPT_RST_BYTE;
		tc_clr = `SPT_RST_BYTE;
		tc_set[`SPT_TC_OVF_A] = ovf_a;
		tc_set[`SPT_TC_OVF_B] = a_split ? split_ovf : ovf_b;
		tc_set[`SPT_TC_FLAG_A] = timer_run_and_flags_reg[`SPT_TC_TYPE_A]
			? falls[2] : lows[2];
		tc_set[`SPT_TC_FLAG_B] = timer_run_and_flags_reg[`SPT_TC_TYPE_B]
			? falls[3] : lows[3];
		tc_clr[`SPT_TC_FLAG_A] = vec_ack_i[0];
		tc_clr[`SPT_TC_OVF_A]  = vec_ack_i[1];
		tc_clr[`SPT_TC_FLAG_B] = vec_ack_i[2];
		tc_clr[`SPT_TC_OVF_B]  = vec_ack_i[3];
	end

	// Timer control with run bits and flags
	always_ff @(posedge sys_clk_i) begin
		if (rst_i) begin
			timer_run_and_flags_reg <= `SPT_RST_BYTE;
		end else if (ce_i) begin
			timer_run_and_flags_reg <= ((wr_timer_run_and_flags ? acc.dat
				: timer_run_and_flags_reg) & ~tc_clr) | tc_set;
		end
	end

	// ------------------------------------------------------------
	// Baud generation
	// ------------------------------------------------------------
	spt_smode_e smode;
	logic       dbl, tick16, half_reg, bit_tick;
	logic [1:0] div_reg;
	logic [3:0] tx_div_reg;
	assign smode = spt_smode_e'(serial_port_control_reg[`SPT_SC_MODE]);
	assign dbl   = power_control_reg[`SPT_PC_DBL];

	// Oversample tick: fixed clock fraction or timer B overflow
	always_comb begin
		case (smode)
			SPT_SM_UART9F: tick16 = ce_i & (div_reg == (dbl
				? `SPT_M2_DIV_FAST : `SPT_M2_DIV_SLOW));
			SPT_SM_UART8, SPT_SM_UART9T:
				tick16 = ovf_b & (dbl | half_reg);
			default: tick16 = 1'b0;
		endcase
	end
	assign bit_tick = tick16 & (tx_div_reg == `SPT_OS_LAST);

	// Dividers free run so bit edges stay locked to rollovers
	always_ff @(posedge sys_clk_i) begin
		if (rst_i) begin
			div_reg    <= 2'h0;
			half_reg   <= 1'b0;
			tx_div_reg <= 4'h0;
		end else if (ce_i) begin
			div_reg <= (tick16 || smode != SPT_SM_UART9F)
				? 2'h0 : div_reg + 2'h1;
			if (ovf_b) half_reg <= ~half_reg;
			if (tick16) tx_div_reg <= tx_div_reg + 4'h1;
		end
	end

	// ------------------------------------------------------------
	// Serial transmit, modes 1 to 3
	// ------------------------------------------------------------
	logic        tx_pend_reg, tx_busy_reg, tx_line_reg, tx_done;
	logic [10:0] tx_shift_reg;
	logic [3:0]  tx_cnt_reg, tx_len;
	assign tx_len  = (smode == SPT_SM_UART8) ? `SPT_BITS_M1 : `SPT_BITS_M23;
	assign tx_done = bit_tick & tx_busy_reg & (tx_cnt_reg == tx_len - 4'h1);

	// Frame shifter; stop bit level is the idle level
	always_ff @(posedge sys_clk_i) begin
		if (rst_i) begin
			tx_pend_reg  <= 1'b0;
			tx_busy_reg  <= 1'b0;
			tx_line_reg  <= 1'b1;
			tx_shift_reg <= 11'h7FF;
			tx_cnt_reg   <= 4'h0;
		end else if (ce_i) begin
			if (wr_serial_buffer && smode != SPT_SM_SHIFT) begin
				tx_pend_reg  <= 1'b1;
				tx_busy_reg  <= 1'b0;
				tx_shift_reg <= {1'b1, (smode == SPT_SM_UART8) ? 1'b1
					: serial_port_control_reg[`SPT_SC_TX9],
					acc.dat, 1'b0};
			end else if (bit_tick && (tx_pend_reg || tx_busy_reg)) begin
				tx_pend_reg  <= 1'b0;
				tx_busy_reg  <= ~tx_done;
				tx_line_reg  <= tx_shift_reg[0];
				tx_shift_reg <= {1'b1, tx_shift_reg[10:1]};
				tx_cnt_reg   <= tx_pend_reg ? 4'h1 : tx_cnt_reg + 4'h1;
			end
		end
	end

	// ------------------------------------------------------------
	// Serial receive, modes 1 to 3
	// ------------------------------------------------------------
	spt_rx_e    rx_state_reg;
	logic       rx_prev_reg, vote_a_reg, vote_b_reg, vote, rx_end;
	logic [3:0] smp_reg, idx_reg;
	logic [7:0] rx_shift_reg;
	logic       rx_keep;
	assign vote = (vote_a_reg & vote_b_reg) | (vote_a_reg & rxd_i)
		| (vote_b_reg & rxd_i);
	assign rx_end = tick16 & (rx_state_reg == SPT_RX_BITS)
		& (smp_reg == `SPT_SMP_9) & (idx_reg == `SPT_RX_LAST);
	assign rx_keep = rx_end & ~serial_port_control_reg[`SPT_SC_RXC]
		& (~serial_port_control_reg[`SPT_SC_FILT] | vote);

	// Edge hunt, sixteen samples per bit, vote at mid bit
	always_ff @(posedge sys_clk_i) begin
		if (rst_i) begin
			rx_state_reg <= SPT_RX_IDLE;
			rx_prev_reg  <= 1'b1;
			vote_a_reg   <= 1'b1;
			vote_b_reg   <= 1'b1;
			smp_reg      <= 4'h0;
			idx_reg      <= 4'h0;
			rx_shift_reg <= `SPT_RST_BYTE;
		end else if (ce_i && tick16) begin
			rx_prev_reg <= rxd_i;
			case (rx_state_reg)
				SPT_RX_IDLE: begin
					if (serial_port_control_reg[`SPT_SC_REN]
						&& rx_prev_reg && !rxd_i) begin
						rx_state_reg <= SPT_RX_BITS;
						smp_reg      <= 4'h1;
						idx_reg      <= 4'h0;
					end
				end
				SPT_RX_BITS: begin
					smp_reg <= smp_reg + 4'h1;
					if (smp_reg == `SPT_SMP_7) vote_a_reg <= rxd_i;
					if (smp_reg == `SPT_SMP_8) vote_b_reg <= rxd_i;
					if (smp_reg == `SPT_SMP_9) begin
						if (idx_reg == 4'h0 && vote) begin
							rx_state_reg <= SPT_RX_IDLE; // false start
						end else if (rx_end) begin
							rx_state_reg <= SPT_RX_IDLE;
						end else if (idx_reg != 4'h0) begin
							rx_shift_reg <= {vote, rx_shift_reg[7:1]};
						end
					end
					if (smp_reg == `SPT_OS_LAST) idx_reg <= idx_reg + 4'h1;
				end
				default: rx_state_reg <= SPT_RX_IDLE;
			endcase
		end
	end

	// ------------------------------------------------------------
	// Shift register mode 0
	// ------------------------------------------------------------
	logic       m0_act_reg, m0_tx_reg, m0_end, m0_data;
	logic [3:0] m0_cnt_reg;
	logic [7:0] m0_shift_reg;
	assign m0_data = m0_act_reg & (m0_cnt_reg >= `SPT_M0_FIRST)
		& (m0_cnt_reg <= `SPT_M0_LAST);
	assign m0_end  = mc_tick & m0_act_reg & (m0_cnt_reg == `SPT_M0_END);

	// One engine drives both directions on the data pin
	always_ff @(posedge sys_clk_i) begin
		if (rst_i) begin
			m0_act_reg   <= 1'b0;
			m0_tx_reg    <= 1'b0;
			m0_cnt_reg   <= 4'h0;
			m0_shift_reg <= `SPT_RST_BYTE;
		end else if (ce_i) begin
			if (wr_serial_buffer && smode == SPT_SM_SHIFT) begin
				m0_act_reg   <= 1'b1;
				m0_tx_reg    <= 1'b1;
				m0_cnt_reg   <= 4'h0;
				m0_shift_reg <= acc.dat;
			end else if (!m0_act_reg) begin
				if (smode == SPT_SM_SHIFT
					&& serial_port_control_reg[`SPT_SC_REN]
					&& !serial_port_control_reg[`SPT_SC_RXC]) begin
					m0_act_reg <= 1'b1;
					m0_tx_reg  <= 1'b0;
					m0_cnt_reg <= 4'h0;
				end
			end else if (mc_tick) begin
				m0_cnt_reg <= m0_cnt_reg + 4'h1;
				if (m0_end) m0_act_reg <= 1'b0;
				if (m0_data) begin
					m0_shift_reg <= {m0_tx_reg ? 1'b1 : rxd_i,
						m0_shift_reg[7:1]};
				end
			end
		end
	end

	// ------------------------------------------------------------
	// Serial control, buffer and pins
	// ------------------------------------------------------------
	logic [7:0] sc_set;
	always_comb begin
		sc_set = `SPT_RST_BYTE;
		sc_set[`SPT_SC_RXC] = rx_keep | (m0_end & ~m0_tx_reg);
		sc_set[`SPT_SC_TXC] = tx_done | (m0_end & m0_tx_reg);
	end

	// Hardware sets win over a software write in the same cycle
	always_ff @(posedge sys_clk_i) begin
		if (rst_i) begin
			serial_port_control_reg <= `SPT_RST_BYTE;
			serial_buffer_reg       <= `SPT_RST_BYTE;
		end else if (ce_i) begin
			serial_port_control_reg <= (wr_serial_port_control ? acc.dat
				: serial_port_control_reg) | sc_set;
			if (rx_keep) begin
				serial_buffer_reg <= rx_shift_reg;
				serial_port_control_reg[`SPT_SC_RX9] <= vote;
			end else if (m0_end && !m0_tx_reg) begin
				serial_buffer_reg <= m0_shift_reg;
			end
		end
	end

	// Mode 0 clock is low in the first half of each data cycle
	assign txd_o = (smode == SPT_SM_SHIFT)
		? ~(m0_data & (phase_reg < `SPT_MC_HALF)) : tx_line_reg;
	assign rxd_o    = m0_shift_reg[0];
	assign rxd_oe_o = (smode == SPT_SM_SHIFT) & m0_data & m0_tx_reg;
	assign irq_req_o = {serial_port_control_reg[`SPT_SC_RXC]
		| serial_port_control_reg[`SPT_SC_TXC],
		timer_run_and_flags_reg[`SPT_TC_OVF_B],
		timer_run_and_flags_reg[`SPT_TC_FLAG_B],
		timer_run_and_flags_reg[`SPT_TC_OVF_A],
		timer_run_and_flags_reg[`SPT_TC_FLAG_A]};
endmodule
`default_nettype wire

// [design/spt_map.svh]
`ifndef SPT_MAP_SVH
`define SPT_MAP_SVH

// ----------------------------------------------------------------
// Register byte offsets on the bus
// ----------------------------------------------------------------
`define SPT_OFS_TIMER_MODE  8'h00
`define SPT_OFS_TIMER_RUN   8'h04
`define SPT_OFS_SERIAL_CTRL 8'h08
`define SPT_OFS_SERIAL_BUF  8'h0C
`define SPT_OFS_POWER_CTRL  8'h10
`define SPT_OFS_A_LOW       8'h14
`define SPT_OFS_A_HIGH      8'h18
`define SPT_OFS_B_LOW       8'h1C
`define SPT_OFS_B_HIGH      8'h20

// ----------------------------------------------------------------
// Field positions and reset values
// ----------------------------------------------------------------
`define SPT_TC_TYPE_A 0
`define SPT_TC_FLAG_A 1
`define SPT_TC_TYPE_B 2
`define SPT_TC_FLAG_B 3
`define SPT_TC_RUN_A  4
`define SPT_TC_OVF_A  5
`define SPT_TC_RUN_B  6
`define SPT_TC_OVF_B  7
`define SPT_SC_RXC    0
`define SPT_SC_TXC    1
`define SPT_SC_RX9    2
`define SPT_SC_TX9    3
`define SPT_SC_REN    4
`define SPT_SC_MODE   6:5
`define SPT_SC_FILT   7
`define SPT_PC_DBL    7
`define SPT_TIMER_MODE_CONFIG_A    3:0
`define SPT_TIMER_MODE_CONFIG_B    7:4
`define SPT_RST_BYTE  8'h00
`define SPT_RST_WORD  32'h0000_0000

// ----------------------------------------------------------------
// Timing counts
// ----------------------------------------------------------------
`define SPT_MC_LAST    4'hB
`define SPT_MC_HALF    4'h6
`define SPT_M2_DIV_SLOW 2'h3
`define SPT_M2_DIV_FAST 2'h1
`define SPT_OS_LAST    4'hF
`define SPT_SMP_7      4'h6
`define SPT_SMP_8      4'h7
`define SPT_SMP_9      4'h8
`define SPT_RX_LAST    4'h9
`define SPT_BITS_M1    4'hA
`define SPT_BITS_M23   4'hB
`define SPT_M0_FIRST   4'h1
`define SPT_M0_LAST    4'h8
`define SPT_M0_END     4'h9
`define SPT_PRESC_MAX  5'h1F
`define SPT_BYTE_MAX   8'hFF
`define SPT_WORD_MAX   16'hFFFF

`endif

// [design/spt_pkg.sv]
package spt_pkg;

	// ------------------------------------------------------------
	// Timer and serial modes, states, carriers
	// ------------------------------------------------------------
	typedef enum logic [1:0] {
		SPT_TM_13BIT  = 2'b00,
		SPT_TM_16BIT  = 2'b01,
		SPT_TM_RELOAD = 2'b10,
		SPT_TM_SPLIT  = 2'b11
	} spt_tmode_e;

	typedef struct packed {
		logic       gate;
		logic       ct;
		spt_tmode_e mode;
	} spt_tcfg_s;

	typedef enum logic [1:0] {
		SPT_SM_SHIFT = 2'b00,
		SPT_SM_UART8 = 2'b01,
		SPT_SM_UART9F = 2'b10,
		SPT_SM_UART9T = 2'b11
	} spt_smode_e;

	typedef enum logic {
		SPT_RX_IDLE = 1'b0,
		SPT_RX_BITS = 1'b1
	} spt_rx_e;

	typedef struct packed {
		logic       wr;
		logic       rd;
		logic [7:0] adr;
		logic [7:0] dat;
	} spt_acc_s;

endpackage

// [design/spt_edge_sampler.sv]
`timescale 1ns/1ps
`default_nettype none
module spt_edge_sampler
	import spt_pkg::*;
(
	// Clock and control
	input  wire logic sys_clk_i,
	input  wire logic rst_i,
	input  wire logic ce_i,
	input  wire logic tick_i,
	// Pin and results
	input  wire logic pin_i,
	output logic      fall_o,
	output logic      low_o
);
	logic samp_reg;

	// One sample per machine cycle
	always_ff @(posedge sys_clk_i) begin
		if (rst_i) begin
			samp_reg <= 1'b1;
		end else if (ce_i && tick_i) begin
			samp_reg <= pin_i;
		end
	end

	// High sample then low sample counts as one falling edge
	assign fall_o = tick_i & samp_reg & ~pin_i;
	assign low_o  = tick_i & ~pin_i;
endmodule
`default_nettype wire

// [design/spt_timer.sv]
`timescale 1ns/1ps
`default_nettype none
`include "spt_map.svh"
module spt_timer
	import spt_pkg::*;
#(
	parameter bit SPLIT = 1'b0
) (
	// Clock and control
	input  wire logic       sys_clk_i,
	input  wire logic       rst_i,
	input  wire logic       ce_i,
	input  wire logic       mc_tick_i,
	// Configuration
	input  wire spt_tcfg_s  cfg_i,
	input  wire logic       run_i,
	input  wire logic       gate_pin_i,
	input  wire logic       cnt_pulse_i,
	input  wire logic       split_run_i,
	// Software access
	input  wire logic       wr_lo_i,
	input  wire logic       wr_hi_i,
	input  wire logic [7:0] wdata_i,
	// Count and events
	output logic [7:0]      lo_o,
	output logic [7:0]      hi_o,
	output logic            ovf_o,
	output logic            split_ovf_o
);
	logic [7:0] lo_reg;
	logic [7:0] hi_reg;
	logic [7:0] lo_next;
	logic [7:0] hi_next;
	logic       inc;

	// Gate qualifies counting, source is machine cycles or pin edges
	assign inc = run_i & (~cfg_i.gate | gate_pin_i)
		& (cfg_i.ct ? cnt_pulse_i : mc_tick_i);

	// Next count per mode
	always_comb begin
		lo_next     = lo_reg;
		hi_next     = hi_reg;
		ovf_o       = 1'b0;
		split_ovf_o = 1'b0;
		case (cfg_i.mode)
			SPT_TM_13BIT: begin
				if (inc) begin
					lo_next[4:0] = lo_reg[4:0] + 5'h01;
					if (lo_reg[4:0] == `SPT_PRESC_MAX) begin
						hi_next = hi_reg + 8'h01;
						ovf_o   = (hi_reg == `SPT_BYTE_MAX);
					end
				end
			end
			SPT_TM_16BIT: begin
				if (inc) begin
					{hi_next, lo_next} = {hi_reg, lo_reg} + 16'h0001;
					ovf_o = ({hi_reg, lo_reg} == `SPT_WORD_MAX);
				end
			end
			SPT_TM_RELOAD: begin
				if (inc) begin
					if (lo_reg == `SPT_BYTE_MAX) begin
						lo_next = hi_reg;
						ovf_o   = 1'b1;
					end else begin
						lo_next = lo_reg + 8'h01;
					end
				end
			end
			SPT_TM_SPLIT: begin
				// Only the split timer runs here, the other holds
				if (SPLIT) begin
					if (inc) begin
						lo_next = lo_reg + 8'h01;
						ovf_o   = (lo_reg == `SPT_BYTE_MAX);
					end
					if (split_run_i && mc_tick_i) begin
						hi_next     = hi_reg + 8'h01;
						split_ovf_o = (hi_reg == `SPT_BYTE_MAX);
					end
				end
			end
			default: begin
				lo_next = lo_reg;
			end
		endcase
	end

	// Count registers, software write wins over counting
	always_ff @(posedge sys_clk_i) begin
		if (rst_i) begin
			lo_reg <= `SPT_RST_BYTE;
			hi_reg <= `SPT_RST_BYTE;
		end else if (ce_i) begin
			lo_reg <= wr_lo_i ? wdata_i : lo_next;
			hi_reg <= wr_hi_i ? wdata_i : hi_next;
		end
	end

	assign lo_o = lo_reg;
	assign hi_o = hi_reg;
endmodule
`default_nettype wire

// [testbench/spt_top_asserts.sv]
`timescale 1ns/1ps
`default_nettype none
module spt_top_asserts (
	// Clock, reset, enable
	input wire logic        sys_clk_i,
	input wire logic        rst_i,
	input wire logic        ce_i,
	// Bus
	input wire logic        wb_cyc_i,
	input wire logic        wb_stb_i,
	input wire logic        wb_we_i,
	input wire logic [7:0]  wb_adr_i,
	input wire logic [31:0] wb_dat_o,
	input wire logic        wb_ack_o,
	// Pins
	input wire logic        rxd_oe_o,
	input wire logic        txd_o,
	input wire logic [4:0]  irq_req_o
);
	default clocking @(posedge sys_clk_i); endclocking
	default disable iff (rst_i);
	// Bus answers one cycle after it takes a request
	property p_ack; wb_cyc_i && wb_stb_i && !wb_ack_o && ce_i |=> wb_ack_o; endproperty
	a_ack: assert property (p_ack) else $error("ack late");
	property p_ack1; wb_ack_o && ce_i |=> !wb_ack_o; endproperty
	a_ack1: assert property (p_ack1) else $error("ack long");
	property p_hi; wb_ack_o |-> wb_dat_o[31:8] == 24'h0; endproperty
	a_hi: assert property (p_hi) else $error("upper data set");
	property p_unm; wb_ack_o && $past(!wb_we_i && wb_adr_i == 8'h30) |-> wb_dat_o == 32'h0; endproperty
	a_unm: assert property (p_unm) else $error("hole not zero");
	// Serial request mirrors both complete flags
	property p_irq; wb_ack_o && $past(!wb_we_i && wb_adr_i == 8'h08) |-> $past(irq_req_o[4]) == |wb_dat_o[1:0]; endproperty
	a_irq: assert property (p_irq) else $error("serial irq");
	property p_rst; $past(rst_i) |-> irq_req_o == 5'h00 && txd_o; endproperty
	a_rst: assert property (p_rst) else $error("reset state");
	// Shift mode keeps the data pin driven for at least eight clocks once it starts
	property p_oe; $rose(rxd_oe_o) |-> rxd_oe_o[*8]; endproperty
	a_oe: assert property (p_oe) else $error("data short");
	property p_sclk; $fell(txd_o) && rxd_oe_o |-> !txd_o[*6] ##1 txd_o; endproperty
	a_sclk: assert property (p_sclk) else $error("shift clock");
endmodule
bind spt_top spt_top_asserts i_spt_top_asserts (.sys_clk_i, .rst_i, .ce_i,
	.wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_dat_o, .wb_ack_o,
	.rxd_oe_o, .txd_o, .irq_req_o);
`default_nettype wire

// [testbench/spt_serial_peer.sv]
`timescale 1ns/1ps
`default_nettype none
module spt_serial_peer #(
	parameter int BIT = 64
) (
	// Clock and command
	input  wire logic        clk_i,
	input  wire logic        go_i,
	input  wire logic [10:0] frame_i,
	// Line toward the port
	output logic             line_o
);
	// Pull-up holds the idle line high; frame goes out LSB first
	initial begin
		line_o = 1'b1;
		forever begin
			@(posedge clk_i);
			if (go_i) begin
				for (int k = 0; k < 11; k++) begin
					line_o <= frame_i[k];
					repeat (BIT) @(posedge clk_i);
				end
				line_o <= 1'b1;
			end
		end
	end
endmodule
`default_nettype wire

// [testbench/test_serial_port_with_timers.sv]
`timescale 1ns/1ps
`default_nettype none
module test_serial_port_with_timers;
	logic        clk, rst, cyc, stb, we, ea, go, txd, ack, rxl, oe, sd, tp;
	logic [3:0]  vack;
	logic [4:0]  irq;
	logic [7:0]  adr, q, d, m0q;
	logic [31:0] wdat, rdat;
	logic [10:0] frm;
	logic [7:0]  ofs [4] = '{8'h00, 8'h04, 8'h08, 8'h30};
	int          n_errors, checked;
	spt_top i_spt_top (.sys_clk_i(clk), .rst_i(rst), .ce_i(1'b1),
		.wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_sel_i(4'hF),
		.wb_adr_i(adr), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack),
		.timer_a_pin_i(ea), .timer_b_pin_i(1'b1), .ext_irq_a_pin_i(ea),
		.ext_irq_b_pin_i(1'b1), .rxd_i(rxl), .rxd_o(sd),
		.rxd_oe_o(oe), .txd_o(txd), .vec_ack_i(vack), .irq_req_o(irq));
	spt_serial_peer #(.BIT(64)) i_spt_serial_peer (.clk_i(clk), .go_i(go),
		.frame_i(frm), .line_o(rxl));
	// Collect mode 0 data bits at each rising shift clock
	always @(posedge clk) begin
		tp <= txd;
		if (oe && txd && !tp)
			m0q <= {sd, m0q[7:1]};
	end
	// Start, data, ninth bit, stop
	function automatic logic [10:0] m2_frame(input logic [7:0] v);
		return {2'b11, v, 1'b0};
	endfunction
	task automatic chk(input logic [7:0] s, input logic [7:0] e);
		checked++;
		if (s !== e) begin
			n_errors++;
			$display("MISMATCH %0t got %h want %h", $time, s, e);
		end
	endtask
	// One classic cycle; waits for ack, bounded
	task automatic wb(input logic w, input logic [7:0] a, input logic [7:0] v);
		int n;
		n = 0;
		@(posedge clk);
		cyc <= 1'b1;
		stb <= 1'b1;
		we <= w;
		adr <= a;
		wdat <= {24'h0, v};
		do begin
			@(posedge clk);
			n++;
		end while (ack !== 1'b1 && n < 20);
		q = rdat[7:0];
		cyc <= 1'b0;
		stb <= 1'b0;
		if (n >= 20)
			n_errors++;
	endtask
	task automatic give_verdict();
		$display("checks %0d mismatches %0d", checked, n_errors);
		if (n_errors == 0 && checked > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask
	initial begin
		clk = 1'b0;
		forever #4 clk = ~clk;
	end
	// Hang guard, well past the longest sequence
	initial begin
		#100000;
		n_errors++;
		give_verdict();
	end
	initial begin
		{rst, ea, frm} = {2'b11, 11'h7FF};
		{cyc, stb, we, go, adr, wdat, vack} = '0;
		{n_errors, checked} = '0;
		void'($urandom(32'h6806));
		repeat (8) @(posedge clk);
		rst <= 1'b0;
		for (int i = 0; i < 4; i++) begin
			wb(1'b0, ofs[i], 8'h00);
			chk(q, 8'h00);
		end
		$display("reset values done");
		wb(1'b1, 8'h14, 8'hFF);
		wb(1'b1, 8'h18, 8'hFF);
		wb(1'b1, 8'h00, 8'h01);
		wb(1'b1, 8'h04, 8'h10);
		repeat (30) @(posedge clk);
		wb(1'b0, 8'h04, 8'h00);
		chk(q, 8'h30);
		wb(1'b1, 8'h04, 8'h01);
		ea <= 1'b0;
		repeat (30) @(posedge clk);
		ea <= 1'b1;
		wb(1'b0, 8'h04, 8'h00);
		chk(q, 8'h03);
		chk({3'h0, irq}, 8'h01);
		vack <= 4'h1;
		@(posedge clk);
		vack <= 4'h0;
		wb(1'b0, 8'h04, 8'h00);
		chk(q, 8'h01);
		// Counter function: two pin pulses give two counts
		wb(1'b1, 8'h14, 8'h00);
		wb(1'b1, 8'h00, 8'h05);
		wb(1'b1, 8'h04, 8'h11);
		repeat (2) begin
			ea <= 1'b0;
			repeat (30) @(posedge clk);
			ea <= 1'b1;
			repeat (30) @(posedge clk);
		end
		wb(1'b0, 8'h14, 8'h00);
		chk(q, 8'h02);
		$display("timer and edge done");
		wb(1'b1, 8'h08, 8'h00);
		d = 8'($urandom);
		wb(1'b1, 8'h0C, d);
		repeat (130) @(posedge clk);
		wb(1'b0, 8'h08, 8'h00);
		chk(q, 8'h02);
		chk(m0q, d);
		$display("shift transmit done");
		// Second frame arrives while the flag is still set and is dropped
		wb(1'b1, 8'h08, 8'h50);
		d = 8'($urandom);
		for (int i = 0; i < 2; i++) begin
			frm <= m2_frame(i ? ~d : d);
			go <= 1'b1;
			@(posedge clk);
			go <= 1'b0;
			repeat (760) @(posedge clk);
			wb(1'b0, 8'h08, 8'h00);
			chk(q, 8'h55);
			wb(1'b0, 8'h0C, 8'h00);
			chk(q, d);
		end
		$display("receive done");
		wb(1'b1, 8'h08, 8'h48);
		wb(1'b1, 8'h0C, 8'($urandom));
		repeat (780) @(posedge clk);
		wb(1'b0, 8'h08, 8'h00);
		chk(q, 8'h4A);
		chk({7'h0, txd}, 8'h01);
		$display("transmit done");
		give_verdict();
	end
endmodule
`default_nettype wire
